// ### hw/bfbe_params.svh
// constants of the bit, flag and branch execution block
`ifndef BFBE_PARAMS_SVH
`define BFBE_PARAMS_SVH

// ****************************************
// apb byte offsets
// ****************************************
`define BFBE_OFS_CMD 12'h000
`define BFBE_OFS_STATUS 12'h004
`define BFBE_OFS_PC 12'h008
`define BFBE_OFS_WREG 12'h100
`define BFBE_OFS_IO 12'h200
`define BFBE_WIN_MASK 12'hF80

// ****************************************
// command word fields and status busy bit
// ****************************************
`define BFBE_CMD_OP_LSB 0
`define BFBE_CMD_IDX_LSB 5
`define BFBE_CMD_BIT_LSB 10
`define BFBE_CMD_K_LSB 16
`define BFBE_STAT_BUSY 8

// ****************************************
// status register bit positions
// ****************************************
`define BFBE_FLAG_C 0
`define BFBE_FLAG_Z 1
`define BFBE_FLAG_N 2
`define BFBE_FLAG_V 3
`define BFBE_FLAG_S 4
`define BFBE_FLAG_H 5
`define BFBE_FLAG_T 6
`define BFBE_FLAG_I 7

// ****************************************
// reset values and cycle counts
// ****************************************
`define BFBE_RST_STATUS_REGISTER 8'h00
`define BFBE_RST_PC 16'h0000
`define BFBE_RST_BYTE 8'h00
`define BFBE_CYC_SHORT 1
`define BFBE_CYC_LONG 2

`endif

// ### hw/bfbe_pkg.sv
// types of the bit, flag and branch execution block
package bfbe_pkg;

    typedef enum logic [4:0] {
        OP_NOP = 5'h00,
        OP_BRANCH_OVERFLOW_CLEAR = 5'h01,
        OP_BRANCH_IRQ_ENABLED = 5'h02,
        OP_BRANCH_IRQ_DISABLED = 5'h03,
        OP_SET_IO_BIT = 5'h04,
        OP_CLEAR_IO_BIT = 5'h05,
        OP_LOGICAL_SHIFT_LEFT = 5'h06,
        OP_LOGICAL_SHIFT_RIGHT = 5'h07,
        OP_ROTATE_LEFT_CARRY = 5'h08,
        OP_ROTATE_RIGHT_CARRY = 5'h09,
        OP_ARITH_SHIFT_RIGHT = 5'h0A,
        OP_NIBBLE_SWAP = 5'h0B,
        OP_FLAG_BIT_SET = 5'h0C,
        OP_FLAG_BIT_CLEAR = 5'h0D,
        OP_BIT_STORE_TO_T = 5'h0E,
        OP_BIT_LOAD_FROM_T = 5'h0F,
        OP_SET_CARRY_FLAG = 5'h10,
        OP_CLEAR_CARRY_FLAG = 5'h11,
        OP_SET_NEGATIVE_FLAG = 5'h12,
        OP_CLEAR_NEGATIVE_FLAG = 5'h13,
        OP_SET_ZERO_FLAG = 5'h14,
        OP_CLEAR_ZERO_FLAG = 5'h15,
        OP_GLOBAL_IRQ_ON = 5'h16,
        OP_GLOBAL_IRQ_OFF = 5'h17,
        OP_SET_SIGN_FLAG = 5'h18,
        OP_CLEAR_SIGN_FLAG = 5'h19,
        OP_SET_OVERFLOW_FLAG = 5'h1A,
        OP_CLEAR_OVERFLOW_FLAG = 5'h1B,
        OP_SET_T_FLAG = 5'h1C,
        OP_CLEAR_T_FLAG = 5'h1D,
        OP_SET_HALF_CARRY = 5'h1E,
        OP_CLEAR_HALF_CARRY = 5'h1F
    } bfbe_op_e;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h1,
        ST_EXEC = 3'h2,
        ST_SECOND = 3'h4
    } bfbe_fsm_e;

    typedef enum logic [2:0] {
        RG_CMD, RG_STATUS, RG_PC, RG_WREG, RG_IO, RG_NONE
    } bfbe_reg_e;

    typedef struct packed {
        bfbe_op_e op;
        logic [4:0] idx;
        logic [2:0] bsel;
        logic [6:0] k;
    } bfbe_cmd_s;

    typedef struct packed {
        logic [7:0] res;
        logic c;
        logic z;
        logic n;
        logic v;
    } bfbe_shift_s;

    typedef struct packed {
        bfbe_fsm_e fsm;
        bfbe_cmd_s cmd;
        logic [15:0] pc;
        logic [7:0] status_register;
        logic [31:0][7:0] wreg;
        logic [31:0][7:0] io;
        logic [31:0] rdata;
    } bfbe_state_s;

endpackage : bfbe_pkg

// ### hw/bfbe_shift_unit.sv
// shift, rotate and swap datapath with flag results
`timescale 1ns/1ps
`default_nettype none
module bfbe_shift_unit (
    input wire bfbe_pkg::bfbe_op_e op,
    input wire logic [7:0] value,
    input wire logic carry_in,
    output bfbe_pkg::bfbe_shift_s out
);
    always_comb begin
        out.res = value;
        out.c = carry_in;
        case (op)
            bfbe_pkg::OP_LOGICAL_SHIFT_LEFT: begin
                out.res = {value[6:0], 1'b0};
                out.c = value[7];
            end
            bfbe_pkg::OP_LOGICAL_SHIFT_RIGHT: begin
                out.res = {1'b0, value[7:1]};
                out.c = value[0];
            end
            bfbe_pkg::OP_ROTATE_LEFT_CARRY: begin
                out.res = {value[6:0], carry_in};
                out.c = value[7];
            end
            bfbe_pkg::OP_ROTATE_RIGHT_CARRY: begin
                out.res = {carry_in, value[7:1]};
                out.c = value[0];
            end
            bfbe_pkg::OP_ARITH_SHIFT_RIGHT: begin
                out.res = {value[7], value[7:1]};
                out.c = value[0];
            end
            bfbe_pkg::OP_NIBBLE_SWAP: begin
                out.res = {value[3:0], value[7:4]};
            end
            default: begin
                out.res = value;
            end
        endcase
        out.z = (out.res == 8'h00);
        out.n = out.res[7];
        // overflow after a shift is negative xor carry
        out.v = out.n ^ out.c;
    end
endmodule : bfbe_shift_unit
`default_nettype wire

// ### hw/bfbe_core.sv
// bit, flag and branch execution slice with an apb register port
// Functional notes
// - Overflow-clear branch jumps to pc plus offset plus one when V is zero, else steps on, no flags changed.
// - Irq-enabled branch jumps when I is one and irq-disabled branch when I is zero, no flags changed.
// - Io bit set and clear force one bit of an io register, leave the rest and the flags, and take two cycles.
// - Logical left shift inserts zero at bit 0 and updates Z, C, N and V in one cycle.
// - Logical right shift inserts zero at bit 7 and updates Z, C, N and V in one cycle.
// - Left rotate fills bit 0 from carry, puts old bit 7 in carry, and updates Z, C, N, V in one cycle.
// - Right rotate fills bit 7 from carry, puts old bit 0 in carry, and updates Z, C, N, V in one cycle.
// - Arithmetic right shift keeps bit 7 and updates Z, C, N and V in one cycle.
// - Bit store copies a register bit into T, changing only T, in one cycle.
// - Bit load copies T into a register bit, changing no flag, in one cycle.
// - Dedicated set commands force C, N, Z, S, V, T or I to one alone in one cycle.
// - Dedicated clear commands force C, N, Z, S, V, T or I to zero alone in one cycle.
// - Dedicated commands set or clear H alone in one cycle.
//
// Implementation choices: the register addresses and register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "bfbe_params.svh"
module bfbe_core (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr
);

    // ****************************************
    // helpers
    // ****************************************
    function automatic bfbe_pkg::bfbe_reg_e decode(input logic [11:0] a);
        bfbe_pkg::bfbe_reg_e r;
        r = bfbe_pkg::RG_NONE;
        if (a[1:0] != 2'h0) begin
            r = bfbe_pkg::RG_NONE;
        end else if (a == `BFBE_OFS_CMD) begin
            r = bfbe_pkg::RG_CMD;
        end else if (a == `BFBE_OFS_STATUS) begin
            r = bfbe_pkg::RG_STATUS;
        end else if (a == `BFBE_OFS_PC) begin
            r = bfbe_pkg::RG_PC;
        end else if ((a & `BFBE_WIN_MASK) == `BFBE_OFS_WREG) begin
            r = bfbe_pkg::RG_WREG;
        end else if ((a & `BFBE_WIN_MASK) == `BFBE_OFS_IO) begin
            r = bfbe_pkg::RG_IO;
        end
        return r;
    endfunction : decode

    function automatic logic [7:0] put_bit(input logic [7:0] v, input logic [2:0] pos, input logic b);
        logic [7:0] r;
        r = v;
        r[pos] = b;
        return r;
    endfunction : put_bit

    // ****************************************
    // state
    // ****************************************
    bfbe_pkg::bfbe_state_s st;
    bfbe_pkg::bfbe_state_s next_st;
    bfbe_pkg::bfbe_shift_s sh;
    bfbe_pkg::bfbe_reg_e sel;
    logic busy;
    logic acc_done;
    logic [4:0] word_idx;
    logic [7:0] cur_reg;
    logic [15:0] branch_target;
    logic branch_cond;
    logic is_branch;

    assign busy = (st.fsm != bfbe_pkg::ST_IDLE);
    assign sel = decode(paddr);
    assign word_idx = paddr[6:2];
    assign cur_reg = st.wreg[st.cmd.idx];
    // writes wait while a command runs, reads never wait
    assign pready = !(busy && pwrite);
    assign acc_done = psel && penable && pready;
    assign pslverr = acc_done && (sel == bfbe_pkg::RG_NONE);
    assign prdata = st.rdata;
    assign branch_target = st.pc + {{9{st.cmd.k[6]}}, st.cmd.k} + 16'h0001;

    bfbe_shift_unit u_shift (
        .op(st.cmd.op),
        .value(cur_reg),
        .carry_in(st.status_register[`BFBE_FLAG_C]),
        .out(sh)
    );

    always_comb begin
        case (st.cmd.op)
            bfbe_pkg::OP_BRANCH_OVERFLOW_CLEAR: begin
                branch_cond = !st.status_register[`BFBE_FLAG_V];
                is_branch = 1'b1;
            end
            bfbe_pkg::OP_BRANCH_IRQ_ENABLED: begin
                branch_cond = st.status_register[`BFBE_FLAG_I];
                is_branch = 1'b1;
            end
            bfbe_pkg::OP_BRANCH_IRQ_DISABLED: begin
                branch_cond = !st.status_register[`BFBE_FLAG_I];
                is_branch = 1'b1;
            end
            default: begin
                branch_cond = 1'b0;
                is_branch = 1'b0;
            end
        endcase
    end

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        next_st = st;
        case (st.fsm)
            bfbe_pkg::ST_IDLE: begin
                next_st.fsm = bfbe_pkg::ST_IDLE;
            end
            bfbe_pkg::ST_EXEC: begin
                next_st.fsm = bfbe_pkg::ST_IDLE;
                next_st.pc = st.pc + 16'h0001;
                if (is_branch && branch_cond) begin
                    next_st.pc = branch_target;
                    next_st.fsm = bfbe_pkg::ST_SECOND;
                end
                case (st.cmd.op)
                    bfbe_pkg::OP_SET_IO_BIT, bfbe_pkg::OP_CLEAR_IO_BIT: begin
                        next_st.pc = st.pc;
                        next_st.fsm = bfbe_pkg::ST_SECOND;
                    end
                    bfbe_pkg::OP_LOGICAL_SHIFT_LEFT, bfbe_pkg::OP_LOGICAL_SHIFT_RIGHT,
                    bfbe_pkg::OP_ROTATE_LEFT_CARRY, bfbe_pkg::OP_ROTATE_RIGHT_CARRY,
                    bfbe_pkg::OP_ARITH_SHIFT_RIGHT: begin
                        next_st.wreg[st.cmd.idx] = sh.res;
                        next_st.status_register[`BFBE_FLAG_C] = sh.c;
                        next_st.status_register[`BFBE_FLAG_Z] = sh.z;
                        next_st.status_register[`BFBE_FLAG_N] = sh.n;
                        next_st.status_register[`BFBE_FLAG_V] = sh.v;
                    end
                    bfbe_pkg::OP_NIBBLE_SWAP: begin
                        next_st.wreg[st.cmd.idx] = sh.res;
                    end
                    bfbe_pkg::OP_FLAG_BIT_SET: begin
                        next_st.status_register = put_bit(st.status_register, st.cmd.bsel, 1'b1);
                    end
                    bfbe_pkg::OP_FLAG_BIT_CLEAR: begin
                        next_st.status_register = put_bit(st.status_register, st.cmd.bsel, 1'b0);
                    end
                    bfbe_pkg::OP_BIT_STORE_TO_T: begin
                        next_st.status_register[`BFBE_FLAG_T] = cur_reg[st.cmd.bsel];
                    end
                    bfbe_pkg::OP_BIT_LOAD_FROM_T: begin
                        next_st.wreg[st.cmd.idx] =
                            put_bit(cur_reg, st.cmd.bsel, st.status_register[`BFBE_FLAG_T]);
                    end
                    bfbe_pkg::OP_SET_CARRY_FLAG: begin
                        next_st.status_register[`BFBE_FLAG_C] = 1'b1;
                    end
                    bfbe_pkg::OP_CLEAR_CARRY_FLAG: begin
                        next_st.status_register[`BFBE_FLAG_C] = 1'b0;
                    end
                    bfbe_pkg::OP_SET_NEGATIVE_FLAG: begin
                        next_st.status_register[`BFBE_FLAG_N] = 1'b1;
                    end
                    bfbe_pkg::OP_CLEAR_NEGATIVE_FLAG: begin
                        next_st.status_register[`BFBE_FLAG_N] = 1'b0;
                    end
                    bfbe_pkg::OP_SET_ZERO_FLAG: begin
                        next_st.status_register[`BFBE_FLAG_Z] = 1'b1;
                    end
                    bfbe_pkg::OP_CLEAR_ZERO_FLAG: begin
                        next_st.status_register[`BFBE_FLAG_Z] = 1'b0;
                    end
                    bfbe_pkg::OP_GLOBAL_IRQ_ON: begin
                        next_st.status_register[`BFBE_FLAG_I] = 1'b1;
                    end
                    bfbe_pkg::OP_GLOBAL_IRQ_OFF: begin
                        next_st.status_register[`BFBE_FLAG_I] = 1'b0;
                    end
                    bfbe_pkg::OP_SET_SIGN_FLAG: begin
                        next_st.status_register[`BFBE_FLAG_S] = 1'b1;
                    end
                    bfbe_pkg::OP_CLEAR_SIGN_FLAG: begin
                        next_st.status_register[`BFBE_FLAG_S] = 1'b0;
                    end
                    bfbe_pkg::OP_SET_OVERFLOW_FLAG: begin
                        next_st.status_register[`BFBE_FLAG_V] = 1'b1;
                    end
                    bfbe_pkg::OP_CLEAR_OVERFLOW_FLAG: begin
                        next_st.status_register[`BFBE_FLAG_V] = 1'b0;
                    end
                    bfbe_pkg::OP_SET_T_FLAG: begin
                        next_st.status_register[`BFBE_FLAG_T] = 1'b1;
                    end
                    bfbe_pkg::OP_CLEAR_T_FLAG: begin
                        next_st.status_register[`BFBE_FLAG_T] = 1'b0;
                    end
                    bfbe_pkg::OP_SET_HALF_CARRY: begin
                        next_st.status_register[`BFBE_FLAG_H] = 1'b1;
                    end
                    bfbe_pkg::OP_CLEAR_HALF_CARRY: begin
                        next_st.status_register[`BFBE_FLAG_H] = 1'b0;
                    end
                    default: begin
                        next_st.wreg = st.wreg;
                    end
                endcase
            end
            bfbe_pkg::ST_SECOND: begin
                next_st.fsm = bfbe_pkg::ST_IDLE;
                // io bit commit in the second cycle, branch target already loaded
                if (st.cmd.op == bfbe_pkg::OP_SET_IO_BIT) begin
                    next_st.io[st.cmd.idx] = put_bit(st.io[st.cmd.idx], st.cmd.bsel, 1'b1);
                    next_st.pc = st.pc + 16'h0001;
                end else if (st.cmd.op == bfbe_pkg::OP_CLEAR_IO_BIT) begin
                    next_st.io[st.cmd.idx] = put_bit(st.io[st.cmd.idx], st.cmd.bsel, 1'b0);
                    next_st.pc = st.pc + 16'h0001;
                end
            end
            default: begin
                next_st.fsm = bfbe_pkg::ST_IDLE;
            end
        endcase

        // ****************************************
        // apb access
        // ****************************************
        if (psel && !penable && !pwrite) begin
            case (sel)
                bfbe_pkg::RG_CMD: next_st.rdata = {8'h00, 1'b0, st.cmd.k, 3'h0, st.cmd.bsel, st.cmd.idx, st.cmd.op};
                bfbe_pkg::RG_STATUS: next_st.rdata = {23'h000000, busy, st.status_register};
                bfbe_pkg::RG_PC: next_st.rdata = {16'h0000, st.pc};
                bfbe_pkg::RG_WREG: next_st.rdata = {24'h000000, st.wreg[word_idx]};
                bfbe_pkg::RG_IO: next_st.rdata = {24'h000000, st.io[word_idx]};
                default: next_st.rdata = 32'h00000000;
            endcase
        end
        if (acc_done && pwrite) begin
            case (sel)
                bfbe_pkg::RG_CMD: begin
                    next_st.cmd.op = bfbe_pkg::bfbe_op_e'(pwdata[`BFBE_CMD_OP_LSB +: 5]);
                    next_st.cmd.idx = pwdata[`BFBE_CMD_IDX_LSB +: 5];
                    next_st.cmd.bsel = pwdata[`BFBE_CMD_BIT_LSB +: 3];
                    next_st.cmd.k = pwdata[`BFBE_CMD_K_LSB +: 7];
                    next_st.fsm = bfbe_pkg::ST_EXEC;
                end
                bfbe_pkg::RG_STATUS: next_st.status_register = pwdata[7:0];
                bfbe_pkg::RG_PC: next_st.pc = pwdata[15:0];
                bfbe_pkg::RG_WREG: next_st.wreg[word_idx] = pwdata[7:0];
                bfbe_pkg::RG_IO: next_st.io[word_idx] = pwdata[7:0];
                default: next_st.rdata = st.rdata;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st.fsm <= bfbe_pkg::ST_IDLE;
            st.cmd <= '0;
            st.pc <= `BFBE_RST_PC;
            st.status_register <= `BFBE_RST_STATUS_REGISTER;
            st.wreg <= {32{`BFBE_RST_BYTE}};
            st.io <= {32{`BFBE_RST_BYTE}};
            st.rdata <= 32'h00000000;
        end else begin
            st <= next_st;
        end
    end

endmodule : bfbe_core
`default_nettype wire

// ### bench/bfbe_chk.sv
// apb port checker of the bit, flag and branch block
`timescale 1ns/1ps
`default_nettype none
module bfbe_chk (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    logic [1:0] since_cmd;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ****************************************
    // edges since the last accepted command
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            since_cmd <= 2'h3;
        end else if (psel && penable && pwrite && pready && paddr == 12'h000) begin
            since_cmd <= 2'h0;
        end else if (since_cmd != 2'h3) begin
            since_cmd <= since_cmd + 2'h1;
        end
    end
    sequence s_cmd_acc;
        psel && penable && pwrite && pready && paddr == 12'h000;
    endsequence
    sequence s_bad_read;
        psel && !penable && !pwrite && paddr[1:0] != 2'h0;
    endsequence
    // ****************************************
    // assertions
    // ****************************************
    a_read_no_wait: assert property (psel && penable && !pwrite |-> pready)
        else $error("read access was stretched");
    a_err_in_access: assert property (pslverr |-> psel && penable && pready)
        else $error("error flag outside an access cycle");
    a_err_misalign: assert property (psel && penable && pready && paddr[1:0] != 2'h0 |-> pslverr)
        else $error("misaligned access not flagged");
    a_cmd_no_err: assert property (psel && penable && paddr == 12'h000 |-> !pslverr)
        else $error("command access flagged");
    a_wreg_no_err: assert property (psel && penable && paddr[11:7] == 5'h02 && paddr[1:0] == 2'h0 |-> !pslverr)
        else $error("working register access flagged");
    a_ready_after_cmd: assert property (since_cmd >= 2'h2 |-> pready)
        else $error("busy longer than two cycles");
    a_cmd_stall_bound: assert property (s_cmd_acc ##1 (psel && pwrite) |-> ##[1:3] (penable && pready))
        else $error("write after command stalled too long");
    a_prdata_hold: assert property (!(psel && !penable && !pwrite) |=> $stable(prdata))
        else $error("read data changed without a read");
    a_bad_read_zero: assert property (s_bad_read |=> prdata == 32'h0)
        else $error("misaligned read returned data");
endmodule : bfbe_chk
bind bfbe_core bfbe_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
`default_nettype wire

// ### bench/testbench.sv
// self-checking testbench of the bit, flag and branch block
`timescale 1ns/1ps
`default_nettype none
`include "bfbe_params.svh"
module testbench;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    int n_mismatch = 0;
    int total_checks = 0;
    int cycles = 0;
    int waits;
    logic [31:0] q;
    logic err;
    logic [7:0] sr;
    logic [7:0] m;
    logic [9:0] sx;
    logic [15:0] pcx;
    logic [4:0] op;
    logic [2:0] fb;
    logic taken;
    logic [7:0] vals [4] = '{8'h00, 8'h80, 8'h01, 8'hC3};
    logic [2:0] fmap [8] = '{3'h0, 3'h2, 3'h1, 3'h7, 3'h4, 3'h3, 3'h6, 3'h5};

    always #4 pclk = ~pclk;

    bfbe_core DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : report_and_stop

    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_mismatch = n_mismatch + 1;
            report_and_stop();
        end
    end

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    // one apb transfer; leaves the bus in its access state so the next may follow at once
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        waits = 0;
        // ready, read data and error are taken at the rising edge that ends the access
        @(posedge pclk);
        while (pready !== 1'b1) begin
            waits++;
            @(posedge pclk);
        end
        q = prdata;
        err = pslverr;
    endtask : xfer

    // command followed by a stalled write whose wait states give the command length
    task automatic run(input logic [4:0] o, input logic [4:0] idx, input logic [2:0] b, input logic [6:0] k,
            input int cyc);
        xfer(1'b1, `BFBE_OFS_CMD, {9'h000, k, 3'h0, b, idx, o});
        xfer(1'b1, 12'h17C, 32'h0);
        chk("cycles", cyc - 1, waits);
    endtask : run

    function automatic logic [9:0] shx(input logic [4:0] o, input logic [7:0] v, input logic c);
        case (o)
            5'h06: return {1'b1, v[7], v[6:0], 1'b0};
            5'h07: return {1'b1, v[0], 1'b0, v[7:1]};
            5'h08: return {1'b1, v[7], v[6:0], c};
            5'h09: return {1'b1, v[0], c, v[7:1]};
            5'h0A: return {1'b1, v[0], v[7], v[7:1]};
            default: return {1'b0, c, v[3:0], v[7:4]};
        endcase
    endfunction : shx

    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        xfer(1'b0, `BFBE_OFS_STATUS, 32'h0);
        chk("status reset", 32'h0, q);
        xfer(1'b0, `BFBE_OFS_PC, 32'h0);
        chk("pc reset", 32'h0, q);
        // ****************************************
        // shifts, rotates and swap
        // ****************************************
        for (int i = 0; i < 24; i++) begin
            op = 5'h06 + 5'(i / 4);
            sr = (i % 2 == 1) ? 8'hFF : 8'h70;
            xfer(1'b1, `BFBE_OFS_WREG + 12'h00C, 32'(vals[i % 4]));
            xfer(1'b1, `BFBE_OFS_STATUS, 32'(sr));
            run(op, 5'h03, 3'h0, 7'h00, 1);
            sx = shx(op, vals[i % 4], sr[0]);
            if (sx[9]) begin
                sr[0] = sx[8];
                sr[1] = (sx[7:0] == 8'h00);
                sr[2] = sx[7];
                sr[3] = sx[7] ^ sx[8];
            end
            xfer(1'b0, `BFBE_OFS_WREG + 12'h00C, 32'h0);
            chk("shift result", 32'(sx[7:0]), q);
            xfer(1'b0, `BFBE_OFS_STATUS, 32'h0);
            chk("shift flags", 32'(sr), q);
        end
        // ****************************************
        // conditional branches
        // ****************************************
        for (int i = 0; i < 12; i++) begin
            op = 5'h01 + 5'(i % 3);
            sr = ((i / 3) % 2 == 1) ? 8'h88 : 8'h77;
            taken = (op == 5'h01) ? !sr[3] : ((op == 5'h02) ? sr[7] : !sr[7]);
            m = (i >= 6) ? 8'h7E : 8'h05;
            xfer(1'b1, `BFBE_OFS_STATUS, 32'(sr));
            xfer(1'b1, `BFBE_OFS_PC, 32'h100);
            run(op, 5'h00, 3'h0, m[6:0], taken ? 2 : 1);
            pcx = taken ? 16'h0101 + {{9{m[6]}}, m[6:0]} : 16'h0101;
            xfer(1'b0, `BFBE_OFS_PC, 32'h0);
            chk("branch pc", 32'(pcx), q);
            xfer(1'b0, `BFBE_OFS_STATUS, 32'h0);
            chk("branch flags", 32'(sr), q);
        end
        // ****************************************
        // io bit set and clear
        // ****************************************
        xfer(1'b1, `BFBE_OFS_IO + 12'h024, 32'h5A);
        run(5'h04, 5'h09, 3'h0, 7'h00, 2);
        run(5'h05, 5'h09, 3'h6, 7'h00, 2);
        xfer(1'b0, `BFBE_OFS_IO + 12'h024, 32'h0);
        chk("io bits", 32'h1B, q);
        // a read right after a two-cycle command sees it busy, then the command fields read back
        xfer(1'b1, `BFBE_OFS_CMD, {9'h000, 7'h15, 3'h0, 3'h5, 5'h0A, 5'h04});
        xfer(1'b0, `BFBE_OFS_STATUS, 32'h0);
        chk("busy flag", 32'h1, 32'(q[`BFBE_STAT_BUSY]));
        xfer(1'b0, `BFBE_OFS_CMD, 32'h0);
        chk("command readback", {9'h000, 7'h15, 3'h0, 3'h5, 5'h0A, 5'h04}, q);
        xfer(1'b0, `BFBE_OFS_IO + 12'h028, 32'h0);
        chk("io bit after busy", 32'h20, q);
        // ****************************************
        // dedicated and generic flag commands
        // ****************************************
        for (int i = 0; i < 32; i++) begin
            op = (i < 16) ? 5'h10 + 5'(i) : ((i % 2 == 1) ? 5'h0D : 5'h0C);
            fb = (i < 16) ? fmap[i / 2] : 3'(i / 2 - 8);
            m = 8'h01 << fb;
            sr = (i % 2 == 1) ? (8'h5A | m) : (8'h5A & ~m);
            xfer(1'b1, `BFBE_OFS_STATUS, 32'(sr));
            run(op, 5'h00, fb, 7'h00, 1);
            sr = sr ^ m;
            xfer(1'b0, `BFBE_OFS_STATUS, 32'h0);
            chk("flag command", 32'(sr), q);
        end
        // ****************************************
        // t flag transfers
        // ****************************************
        xfer(1'b1, `BFBE_OFS_WREG + 12'h01C, 32'h24);
        xfer(1'b1, `BFBE_OFS_STATUS, 32'h0);
        run(5'h0E, 5'h07, 3'h2, 7'h00, 1);
        xfer(1'b0, `BFBE_OFS_STATUS, 32'h0);
        chk("t store", 32'h40, q);
        run(5'h0F, 5'h07, 3'h7, 7'h00, 1);
        xfer(1'b0, `BFBE_OFS_WREG + 12'h01C, 32'h0);
        chk("t load", 32'hA4, q);
        run(5'h0E, 5'h07, 3'h3, 7'h00, 1);
        xfer(1'b0, `BFBE_OFS_STATUS, 32'h0);
        chk("t clear", 32'h0, q);
        // ****************************************
        // unmapped and misaligned accesses
        // ****************************************
        xfer(1'b0, 12'h300, 32'h0);
        chk("unmapped err", 32'h1, 32'(err));
        xfer(1'b0, 12'h006, 32'h0);
        chk("misaligned read err", 32'h1, 32'(err));
        chk("misaligned data", 32'h0, q);
        xfer(1'b1, 12'h102, 32'hFF);
        chk("misaligned write err", 32'h1, 32'(err));
        xfer(1'b0, `BFBE_OFS_WREG, 32'h0);
        chk("misaligned no effect", 32'h0, q);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
        report_and_stop();
    end
endmodule : testbench
`default_nettype wire
